// >>> apb_host_model.sv
// Purpose: Control side that drives the generator over APB.
// Assumes: The slave answers with pready.
// Notes: Released write data is inverted so stale values cannot pass.
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
	input  wire logic        sys_clk,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [11:0] paddr,
	output var  logic [31:0] pwdata
);
	// Idle bus from time zero.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end
	// The request is held until pready is sampled high.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// >>> ea_gen_checker_assertions.sv
// Purpose: Port checks for the address generator.
// Assumes: APB slave that answers one cycle after setup.
// Notes: Bound to the design top below.
`timescale 1ns/1ps
`default_nettype none
`include "ea_gen_regs.svh"
module ea_gen_checker (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	// One clock domain, so the reset gate is declared once.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence setupPh;
		psel && !penable;
	endsequence
	sequence readOk;
		pready && !pwrite && !pslverr;
	endsequence
	AST_ANSWER: assert property (setupPh |=> pready && psel)
		else $error("No answer after setup.");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("Ready held too long.");
	AST_ACCESS: assert property (pready |-> psel && penable && $past(psel))
		else $error("Ready outside an access.");
	AST_ERRQ: assert property (pslverr |-> pready)
		else $error("Error without ready.");
	AST_UNMAP: assert property (pready && paddr == 12'h02C |-> pslverr)
		else $error("Unmapped access accepted.");
	AST_MAPPED: assert property (pready && paddr <= `EA_OFS_LEVELS |-> !pslverr)
		else $error("Mapped access refused.");
	AST_WIDTH: assert property (readOk |-> prdata[31:24] == 8'h00)
		else $error("Upper read bits set.");
	AST_WADDR: assert property (readOk ##0 paddr == `EA_OFS_MADDR |-> prdata[31:15] == 17'h00000)
		else $error("Word address too wide.");
	AST_CADDR: assert property (readOk ##0 paddr == `EA_OFS_RADDR |-> prdata[31:17] == 15'h0000)
		else $error("Character address too wide.");
endmodule : ea_gen_checker
bind effective_address_generator ea_gen_checker i_chk (.sys_clk(sys_clk), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// >>> ea_gen_pkg.sv
// Purpose: Types shared by the address generator.
// Assumes: Constants live in the _regs header.
// Notes: Mode codes select the address form being produced.
package ea_gen_pkg;
	typedef enum logic [2:0] {
		MODE_NOADDR,
		MODE_WORD,
		MODE_CHAR,
		MODE_SHIFT,
		MODE_BP_CHAR,
		MODE_BP_WORD
	} addr_mode_t;
	typedef struct packed {
		logic        indirect;
		logic [1:0]  idxSel;
		logic [20:0] low;
	} instr_word_t;
	typedef enum {
		ST_IDLE,
		ST_FETCH,
		ST_INDEX,
		ST_LOAD,
		ST_DONE
	} ea_state_t;
endpackage : ea_gen_pkg

// >>> ea_gen_regs.svh
// Purpose: Register offsets, field positions, reset values and storage depth for the address generator.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Included by the design module, the checker and the bench.
`ifndef EA_GEN_REGS_SVH
`define EA_GEN_REGS_SVH
`define EA_OFS_CTRL     12'h000
`define EA_OFS_INSTR    12'h004
`define EA_OFS_IDX1     12'h008
`define EA_OFS_IDX2     12'h00C
`define EA_OFS_IDX3     12'h010
`define EA_OFS_STATUS   12'h014
`define EA_OFS_MADDR    12'h018
`define EA_OFS_RADDR    12'h01C
`define EA_OFS_KCOUNT   12'h020
`define EA_OFS_ACC      12'h024
`define EA_OFS_LEVELS   12'h028
`define EA_CTRL_START   0
`define EA_CTRL_MODE_LO 1
`define EA_CTRL_MODE_HI 3
`define EA_CTRL_FLAG_LO 4
`define EA_CTRL_FLAG_HI 5
`define EA_CTRL_PRESENT 6
`define EA_CTRL_NEEDOPT 7
`define EA_ST_BUSY      0
`define EA_ST_DONE      1
`define EA_ST_TRAP      2
`define EA_INSTR_IND    23
`define EA_INSTR_B_HI   22
`define EA_INSTR_B_LO   21
`define EA_RESET_WORD   24'h000000
`define EA_RESET_CTRL   8'h00
`define EA_MEM_DEPTH    256
`endif

// >>> effective_address_generator.sv
// Purpose: Forms modified word, character and shift addresses, with indirection.
// Assumes: Storage is a local array written and read through APB.
// Notes: Index sums are one's complement with end-around carry.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ea_gen_regs.svh"

// Functional notes
// - Designator zero leaves address unmodified
// - Sign-extend index to bit 16 for characters
// - Field flag picks index for business processor
// - Business word field adds low fifteen bits
// - No-address mode uses low bits directly
// - Indirect flag zero: direct, optionally indexed
// - Indirect flag one fetches storage word; the code fetches in word mode only
// - Indirection repeats until flag clears
// - Indirection and indexing are independent steps
// - Fetched address replaces held instruction address
// - All resolution finishes before the operation
// - Load accumulator takes full 24-bit word
// - Missing option module causes a trap
// - Two-bit designator selects one of three
// - Flag 1 or 3 first, 2 second
// - Word addresses 15 bits, characters 17 bits
module effective_address_generator
	import ea_gen_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	logic [23:0]      mem [0:`EA_MEM_DEPTH-1];
	logic [7:0]       ctrl_reg;
	instr_word_t      instr_reg;
	logic [23:0]      idx1_reg;
	logic [23:0]      idx2_reg;
	logic [23:0]      idx3_reg;
	logic [16:0]      result_reg;
	logic [14:0]      maddr_reg;
	logic [16:0]      raddr_reg;
	logic [14:0]      kcount_reg;
	logic [23:0]      acc_reg;
	logic [7:0]       levels_reg;
	logic             busy_reg;
	logic             done_reg;
	logic             trap_reg;
	ea_state_t        state_reg;
	addr_mode_t       mode;
	logic             apbWrite;
	logic             apbRead;
	logic             startPulse;
	logic [23:0]      idxVal;
	logic [16:0]      modified;
	logic [23:0]      fetched;

	// One's-complement addition with end-around carry over seventeen bits.
	function automatic logic [16:0] ones_add17(input logic [16:0] a, input logic [16:0] b);
		logic [17:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[16:0] + {16'h0000, s[17]};
	endfunction : ones_add17

	// Fifteen-bit form, used for word addresses and shift counts.
	function automatic logic [14:0] ones_add15(input logic [14:0] a, input logic [14:0] b);
		logic [15:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[14:0] + {14'h0000, s[15]};
	endfunction : ones_add15

	// Register index selection: 0 means none, otherwise one of three.
	function automatic logic [23:0] pick_idx(input logic [1:0] sel, input logic [23:0] i1,
		input logic [23:0] i2, input logic [23:0] i3);
		unique case (sel)
			2'h0: return 24'h000000;
			2'h1: return i1;
			2'h2: return i2;
			2'h3: return i3;
		endcase
	endfunction : pick_idx

	// Bus decode; a read is seen in its setup cycle so that its data stands in the access cycle.
	assign mode       = addr_mode_t'(ctrl_reg[`EA_CTRL_MODE_HI:`EA_CTRL_MODE_LO]);
	assign apbWrite   = psel && penable && pwrite;
	assign apbRead    = psel && !penable && !pwrite;
	assign startPulse = apbWrite && paddr == `EA_OFS_CTRL && pwdata[`EA_CTRL_START];
	assign fetched    = mem[instr_reg.low[7:0]];

	// Index register choice; the business processor field flag overrides the designator.
	always_comb begin
		logic [1:0] flag;
		flag = ctrl_reg[`EA_CTRL_FLAG_HI:`EA_CTRL_FLAG_LO];
		if (mode == MODE_BP_CHAR || mode == MODE_BP_WORD) begin
			if (flag == 2'h2) begin
				idxVal = idx2_reg;
			end else if (flag == 2'h0) begin
				idxVal = 24'h000000;
			end else begin
				idxVal = idx1_reg;
			end
		end else begin
			idxVal = pick_idx(instr_reg.idxSel, idx1_reg, idx2_reg, idx3_reg);
		end
	end

	// Address arithmetic per mode; zero index gives the unmodified value.
	always_comb begin
		unique case (mode)
			MODE_NOADDR: modified = {2'b00, instr_reg.low[14:0]};
			// Index values are fifteen bits wide; bit 14 is the sign carried up to bit 16.
			MODE_CHAR, MODE_BP_CHAR: modified = ones_add17(instr_reg.low[16:0],
				{{2{idxVal[14]}}, idxVal[14:0]});
			MODE_BP_WORD: modified = {2'b00, ones_add15(instr_reg.low[14:0],
				idxVal[14:0])};
			// Codes 6 and 7 name no mode; they fall to the word-address form.
			default: modified = {2'b00, ones_add15(instr_reg.low[14:0],
				idxVal[14:0])};
		endcase
	end

	// Resolution sequencer; the operation only runs once resolution ends.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			unique case (state_reg)
				ST_IDLE: if (startPulse) begin
					if (pwdata[`EA_CTRL_NEEDOPT] && !pwdata[`EA_CTRL_PRESENT]) begin
						state_reg <= ST_DONE;
					end else begin
						state_reg <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					// Indirection only applies to word-addressed execution addresses.
					// A chain that points back at itself never ends; software must avoid one.
					if (instr_reg.indirect && mode == MODE_WORD) begin
						state_reg <= ST_FETCH;
					end else begin
						state_reg <= ST_INDEX;
					end
				end
				ST_INDEX: state_reg <= ST_LOAD;
				ST_LOAD:  state_reg <= ST_DONE;
				ST_DONE:  state_reg <= ST_IDLE;
			endcase
		end
	end

	// Held instruction; each fetched word replaces all of it, not just its address part.
	// The whole fetched word is taken, so its own flag and designator steer the next step.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			instr_reg <= instr_word_t'(`EA_RESET_WORD);
		end else if (state_reg == ST_IDLE && apbWrite && paddr == `EA_OFS_INSTR) begin
			instr_reg <= instr_word_t'(pwdata[23:0]);
		end else if (state_reg == ST_FETCH && instr_reg.indirect && mode == MODE_WORD) begin
			instr_reg <= instr_word_t'(fetched);
		end
	end

	// Indirect level count; it wraps to zero on the 256th level, since a chain may be of any length.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			levels_reg <= 8'h00;
		end else if (state_reg == ST_IDLE && apbWrite && paddr == `EA_OFS_INSTR) begin
			levels_reg <= 8'h00;
		end else if (state_reg == ST_FETCH && instr_reg.indirect && mode == MODE_WORD) begin
			levels_reg <= levels_reg + 8'h01;
		end
	end

	// Results: word address, character address and shift count, taken once indexing ends.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			maddr_reg  <= 15'h0000;
			raddr_reg  <= 17'h00000;
			kcount_reg <= 15'h0000;
			result_reg <= 17'h00000;
		end else if (state_reg == ST_INDEX) begin
			result_reg <= modified;
			maddr_reg  <= modified[14:0];
			raddr_reg  <= modified;
			kcount_reg <= modified[14:0];
		end
	end

	// Accumulator load from the final address; only the low 256 words are held here.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			acc_reg <= `EA_RESET_WORD;
		end else if (state_reg == ST_LOAD) begin
			acc_reg <= mem[result_reg[7:0]];
		end
	end

	// Busy flag; it trails the sequencer by one clock, so software should rely on done.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= state_reg != ST_IDLE && state_reg != ST_DONE;
		end
	end

	// Done flag; a new start clears it and the last sequencer step sets it.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			done_reg <= 1'b0;
		end else if (state_reg == ST_DONE) begin
			done_reg <= 1'b1;
		end else if (startPulse && state_reg == ST_IDLE) begin
			done_reg <= 1'b0;
		end
	end

	// Trap flag; it is decided at start and held until the next start.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			trap_reg <= 1'b0;
		end else if (startPulse && state_reg == ST_IDLE) begin
			trap_reg <= pwdata[`EA_CTRL_NEEDOPT] && !pwdata[`EA_CTRL_PRESENT];
		end
	end

	// Control register; the start bit is never stored, so a later write cannot rerun it.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= `EA_RESET_CTRL;
		end else if (apbWrite && state_reg == ST_IDLE && paddr == `EA_OFS_CTRL) begin
			ctrl_reg <= {pwdata[7:1], 1'b0};
		end
	end

	// Index registers; they are frozen during resolution so a sum cannot shift mid-step.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			idx1_reg <= `EA_RESET_WORD;
			idx2_reg <= `EA_RESET_WORD;
			idx3_reg <= `EA_RESET_WORD;
		end else if (apbWrite && state_reg == ST_IDLE) begin
			unique case (paddr)
				`EA_OFS_IDX1: idx1_reg <= pwdata[23:0];
				`EA_OFS_IDX2: idx2_reg <= pwdata[23:0];
				`EA_OFS_IDX3: idx3_reg <= pwdata[23:0];
				default: ;
			endcase
		end
	end

	// Storage image, written through a window above the register block.
	always_ff @(posedge sys_clk) begin
		if (apbWrite && paddr[11:10] == 2'b01) begin
			mem[paddr[9:2]] <= pwdata[23:0];
		end
	end

	// APB answer: zero wait states, error on unmapped addresses.
	// Unaligned register offsets below 028h are refused on reads only; writes to them are dropped.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			if (apbRead) begin
				if (paddr[11:10] == 2'b01) begin
					prdata <= {8'h00, mem[paddr[9:2]]};
				end else begin
					unique case (paddr)
						`EA_OFS_CTRL:   prdata <= {24'h000000, ctrl_reg};
						`EA_OFS_INSTR:  prdata <= {8'h00, instr_reg};
						`EA_OFS_IDX1:   prdata <= {8'h00, idx1_reg};
						`EA_OFS_IDX2:   prdata <= {8'h00, idx2_reg};
						`EA_OFS_IDX3:   prdata <= {8'h00, idx3_reg};
						`EA_OFS_STATUS: prdata <= {29'h00000000, trap_reg, done_reg, busy_reg};
						`EA_OFS_MADDR:  prdata <= {17'h00000, maddr_reg};
						`EA_OFS_RADDR:  prdata <= {15'h0000, raddr_reg};
						`EA_OFS_KCOUNT: prdata <= {17'h00000, kcount_reg};
						`EA_OFS_ACC:    prdata <= {8'h00, acc_reg};
						`EA_OFS_LEVELS: prdata <= {24'h000000, levels_reg};
						default:        pslverr <= 1'b1;
					endcase
				end
			end else if (psel && !penable && paddr[11:10] != 2'b01
				&& paddr > `EA_OFS_LEVELS) begin
				pslverr <= 1'b1;
			end
		end
	end
endmodule : effective_address_generator
`default_nettype wire

// >>> effective_address_generator_bench.sv
// Purpose: Self-checking bench for the address generator.
// Assumes: Result offsets and control fields from the regs header.
// Notes: Expected sums are one's complement, worked by hand.
`timescale 1ns/1ps
`default_nettype none
`include "ea_gen_regs.svh"
`define CHK(g, e) chk(g, e)
module effective_address_generator_bench;
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [23:0] instr;
		logic [11:0] ofs;
		logic [31:0] exp;
	} row_t;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int          num_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	// Index registers hold 13h, F4h and 7FFEh (minus one) below.
	row_t        rows [11] = '{
		'{8'h03, 24'h001234, `EA_OFS_MADDR, 32'h00001234},
		'{8'h03, 24'h600100, `EA_OFS_MADDR, 32'h000000FF},
		'{8'h03, 24'h200100, `EA_OFS_MADDR, 32'h00000113},
		'{8'h05, 24'h600100, `EA_OFS_RADDR, 32'h000000FF},
		'{8'h05, 24'h41FF00, `EA_OFS_RADDR, 32'h0001FFF4},
		'{8'h07, 24'h200005, `EA_OFS_KCOUNT, 32'h00000018},
		'{8'h01, 24'hE00042, `EA_OFS_MADDR, 32'h00000042},
		'{8'h29, 24'h00010B, `EA_OFS_RADDR, 32'h000001FF},
		'{8'h39, 24'h00010B, `EA_OFS_RADDR, 32'h0000011E},
		'{8'h09, 24'h40010B, `EA_OFS_RADDR, 32'h0000010B},
		'{8'h1B, 24'h018200, `EA_OFS_MADDR, 32'h00000213}};
	effective_address_generator i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	apb_host_model i_host (.sys_clk(sys_clk), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));
	initial forever #20 sys_clk = ~sys_clk;
	// A hang is cut short well past the expected run length.
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 8000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic put(input logic [11:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, rd, er);
	endtask : put
	task automatic get(input logic [11:0] a);
		i_host.xfer(1'b0, a, 32'h00000000, rd, er);
	endtask : get
	// Starts one resolution and polls until done; rd then holds status.
	task automatic go(input logic [7:0] c, input logic [23:0] ins);
		int n;
		put(`EA_OFS_INSTR, {8'h00, ins});
		put(`EA_OFS_CTRL, {24'h000000, c});
		n = 0;
		do begin
			get(`EA_OFS_STATUS);
			n++;
		end while (rd[1] !== 1'b1 && n < 40);
	endtask : go
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		put(`EA_OFS_IDX1, 32'h00000013);
		put(`EA_OFS_IDX2, 32'h000000F4);
		put(`EA_OFS_IDX3, 32'h00007FFE);
		foreach (rows[k]) begin
			go(rows[k].ctrl, rows[k].instr);
			get(rows[k].ofs);
			`CHK(rd, rows[k].exp);
			$display("row %0d done", k);
		end
		// Two indirect levels, the last one indexed, then a load.
		put(12'h414, 32'h00800009);
		put(12'h424, 32'h00200020);
		put(12'h4CC, 32'h00ABCDEF);
		go(8'h03, 24'h800005);
		get(`EA_OFS_MADDR);
		`CHK(rd, 32'h00000033);
		get(`EA_OFS_ACC);
		`CHK(rd, 32'h00ABCDEF);
		get(`EA_OFS_LEVELS);
		`CHK(rd, 32'h00000002);
		$display("indirect done");
		// A missing option traps and leaves the result alone.
		go(8'h83, 24'h000077);
		`CHK(rd, 32'h00000006);
		get(`EA_OFS_MADDR);
		`CHK(rd, 32'h00000033);
		go(8'hC3, 24'h000077);
		`CHK(rd, 32'h00000002);
		get(12'h02C);
		`CHK({31'h00000000, er}, 32'h00000001);
		$display("trap done");
		// Reset after the last run clears the results.
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		get(`EA_OFS_MADDR);
		`CHK(rd, 32'h00000000);
		$display("reset done");
		tally_and_finish();
	end
endmodule : effective_address_generator_bench
`default_nettype wire
